// File: hdl/urs_consts.vh
// Register map, field positions, reset values and sizes of the receive status block.
`ifndef URS_CONSTS_VH
`define URS_CONSTS_VH

// Bus geometry.
`define URS_ADDR_W 5
`define URS_DATA_W 32
`define URS_RESP_OKAY 2'b00
`define URS_RESP_SLVERR 2'b10

// Register byte offsets.
`define URS_OFF_STATUS 5'h00
`define URS_OFF_CONTROL 5'h04
`define URS_OFF_DIVISOR 5'h08
`define URS_OFF_DATA 5'h0c
`define URS_OFF_IRQ_STATUS 5'h10
`define URS_OFF_IRQ_ENABLE 5'h14
`define URS_OFF_IRQ_CLEAR 5'h18

// Fields of serial_status_control.
`define URS_ST_ADDR_DETECT 5
`define URS_ST_IDLE 4
`define URS_ST_PARITY_ERR 3
`define URS_ST_FRAMING_ERR 2
`define URS_ST_OVERRUN 1
`define URS_ST_DATA_AVAIL 0

// Fields of the character format register.
`define URS_CTL_NINE_BIT 0
`define URS_CTL_PARITY_EN 1
`define URS_CTL_PARITY_ODD 2
`define URS_CTL_W 3
`define URS_CTL_RESET 3'h0

// Bit time in clock cycles; the reset value gives about 115200 baud at 125 MHz.
`define URS_DIV_W 16
`define URS_DIV_RESET 16'h043d

// Interrupt event bits.
`define URS_EV_CHAR 0
`define URS_EV_OVERRUN 1
`define URS_EV_ERROR 2
`define URS_EV_W 3
`define URS_EV_RESET 3'h0

// Receive FIFO: nine data bits, framing error, parity error.
`define URS_FIFO_DEPTH 4
`define URS_FIFO_AW 2
`define URS_FIFO_CW 3
`define URS_FIFO_W 11
`define URS_ENT_FRAMING_ERROR_FLAG 9
`define URS_ENT_PARITY_ERROR_FLAG 10
`define URS_CHAR_W 9

`endif

// File: hdl/urs_rx_fifo.v
// Receive FIFO of flip-flops holding characters together with their error flags.
`timescale 1ns/100ps
`include "urs_consts.vh"

module urs_rx_fifo (
    input wire clock,
    input wire rst_n,
    input wire flush,
    input wire push,
    input wire [`URS_FIFO_W-1:0] pushData,
    input wire pop,
    output wire [`URS_FIFO_W-1:0] headData,
    output wire full,
    output wire empty
);
    reg [`URS_FIFO_W-1:0] store [0:`URS_FIFO_DEPTH-1];
    reg [`URS_FIFO_AW-1:0] wrPtr;
    reg [`URS_FIFO_AW-1:0] rdPtr;
    reg [`URS_FIFO_CW-1:0] count;
    wire doPush;
    wire doPop;

    // A push into a full FIFO is refused here; the caller flags it as overrun.
    assign doPush = push && !full;
    assign doPop = pop && !empty;
    assign full = (count == `URS_FIFO_DEPTH);
    assign empty = (count == {`URS_FIFO_CW{1'b0}});
    assign headData = store[rdPtr];

    // Pointers and occupancy; flush takes precedence over any access.
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wrPtr <= {`URS_FIFO_AW{1'b0}};
            rdPtr <= {`URS_FIFO_AW{1'b0}};
            count <= {`URS_FIFO_CW{1'b0}};
        end else if (flush) begin
            wrPtr <= {`URS_FIFO_AW{1'b0}};
            rdPtr <= {`URS_FIFO_AW{1'b0}};
            count <= {`URS_FIFO_CW{1'b0}};
        end else begin
            if (doPush) begin
                wrPtr <= wrPtr + 1'b1;
            end
            if (doPop) begin
                rdPtr <= rdPtr + 1'b1;
            end
            if (doPush && !doPop) begin
                count <= count + 1'b1;
            end else if (doPop && !doPush) begin
                count <= count - 1'b1;
            end
        end
    end

    // Storage needs no reset; an empty FIFO never exposes its contents as valid.
    always @(posedge clock) begin
        if (doPush && !flush) begin
            store[wrPtr] <= pushData;
        end
    end
endmodule

// File: hdl/urs_receive_status.v
// Serial receiver with status flags, receive FIFO, interrupts and an AXI4-Lite slave.
//
// Added by the designer: the address map and register access over AXI4-Lite.
`timescale 1ns/100ps
`include "urs_consts.vh"

module urs_receive_status (
    input wire clock,
    input wire rst_n,
    input wire rxLine,
    input wire [`URS_ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [`URS_DATA_W-1:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [`URS_ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [`URS_DATA_W-1:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg irq
);
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_START = 3'h1;
    localparam [2:0] ST_DATA = 3'h2;
    localparam [2:0] ST_PARITY = 3'h3;
    localparam [2:0] ST_STOP = 3'h4;

    // Drop the byte-offset bits so that the register decode works on whole words.
    function [`URS_ADDR_W-1:0] alignAddr;
        input [`URS_ADDR_W-1:0] a;
        begin
            alignAddr = {a[`URS_ADDR_W-1:2], 2'b00};
        end
    endfunction

    // A divisor of zero would stall the bit timer, so it is treated as one.
    function [`URS_DIV_W-1:0] bitTime;
        input [`URS_DIV_W-1:0] d;
        begin
            bitTime = (d == {`URS_DIV_W{1'b0}}) ? {{(`URS_DIV_W-1){1'b0}}, 1'b1} : d;
        end
    endfunction

    reg [2:0] rxState;
    reg [`URS_DIV_W-1:0] bitTimer;
    reg [3:0] bitCnt;
    reg [`URS_CHAR_W-1:0] rxShift;
    reg parityBit;
    reg addrDetect;
    reg overrun;
    reg [`URS_CTL_W-1:0] format;
    reg [`URS_DIV_W-1:0] divisor;
    reg [`URS_EV_W-1:0] irqStatus;
    reg [`URS_EV_W-1:0] irqEnable;

    wire wrEn;
    wire rdEn;
    wire [`URS_ADDR_W-1:0] wrAddr;
    wire [`URS_ADDR_W-1:0] rdAddr;
    wire wrLane0;
    wire wrLane1;
    wire nineBit;
    wire parityOn;
    wire [3:0] lastBit;
    wire charDone;
    wire keepChar;
    wire framingBad;
    wire parityBad;
    wire pushChar;
    wire overrunEvent;
    wire overrunClear;
    wire fifoFull;
    wire fifoEmpty;
    wire fifoPop;
    wire [`URS_FIFO_W-1:0] fifoHead;
    wire [`URS_FIFO_W-1:0] fifoIn;
    wire [`URS_EV_W-1:0] events;
    wire [`URS_EV_W-1:0] clearMask;
    reg [`URS_DATA_W-1:0] next_rdata;
    reg [1:0] next_rresp;

    // Bus strobes: a transfer takes effect at the edge where the handshake completes.
    assign wrEn = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    assign rdEn = s_axi_arvalid && s_axi_arready;
    assign wrAddr = alignAddr(s_axi_awaddr);
    assign rdAddr = alignAddr(s_axi_araddr);
    assign wrLane0 = wrEn && s_axi_wstrb[0];
    assign wrLane1 = wrEn && s_axi_wstrb[1];

    // Character format; parity is only framed in eight-bit mode.
    assign nineBit = format[`URS_CTL_NINE_BIT];
    assign parityOn = format[`URS_CTL_PARITY_EN] && !nineBit;
    assign lastBit = nineBit ? 4'h8 : 4'h7;

    // Completion of a character at the middle of its stop bit.
    assign charDone = (rxState == ST_STOP) && (bitTimer == {`URS_DIV_W{1'b0}});
    assign framingBad = !rxLine;
    assign parityBad = parityOn && ((^rxShift[7:0] ^ parityBit) != format[`URS_CTL_PARITY_ODD]);
    assign keepChar = !(addrDetect && nineBit && !rxShift[8]);
    assign pushChar = charDone && keepChar && !fifoFull && !overrun;
    assign overrunEvent = charDone && keepChar && fifoFull && !overrun;
    assign fifoIn = {parityBad, framingBad, nineBit ? rxShift : {1'b0, rxShift[7:0]}};

    // Only a write of zero onto a set flag clears overrun; writing one is ignored.
    assign overrunClear = wrLane0 && (wrAddr == `URS_OFF_STATUS) && overrun
        && !s_axi_wdata[`URS_ST_OVERRUN];

    // Reading the data register removes the head character.
    assign fifoPop = rdEn && (rdAddr == `URS_OFF_DATA);

    urs_rx_fifo u_fifo (
        .clock(clock),
        .rst_n(rst_n),
        .flush(overrunClear),
        .push(pushChar),
        .pushData(fifoIn),
        .pop(fifoPop),
        .headData(fifoHead),
        .full(fifoFull),
        .empty(fifoEmpty)
    );

    // Receive sequencer. The line is taken as synchronous; no glitch filter is applied,
    // so a noisy line may start false frames that the start-bit check mostly rejects.
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rxState <= ST_IDLE;
            bitTimer <= {`URS_DIV_W{1'b0}};
            bitCnt <= 4'h0;
            rxShift <= {`URS_CHAR_W{1'b0}};
            parityBit <= 1'b0;
        end else if (overrunClear) begin
            rxState <= ST_IDLE;
            bitTimer <= {`URS_DIV_W{1'b0}};
            bitCnt <= 4'h0;
            rxShift <= {`URS_CHAR_W{1'b0}};
            parityBit <= 1'b0;
        end else if (rxState != ST_IDLE && bitTimer != {`URS_DIV_W{1'b0}}) begin
            bitTimer <= bitTimer - 1'b1;
        end else begin
            case (rxState)
                ST_IDLE: begin
                    if (!rxLine && !overrun) begin
                        rxState <= ST_START;
                        bitTimer <= bitTime(divisor) >> 1;
                    end
                end
                ST_START: begin
                    if (!rxLine) begin
                        rxState <= ST_DATA;
                        bitTimer <= bitTime(divisor) - 1'b1;
                        bitCnt <= 4'h0;
                        rxShift <= {`URS_CHAR_W{1'b0}};
                    end else begin
                        rxState <= ST_IDLE;
                    end
                end
                ST_DATA: begin
                    rxShift[bitCnt] <= rxLine;
                    bitTimer <= bitTime(divisor) - 1'b1;
                    if (bitCnt == lastBit) begin
                        rxState <= parityOn ? ST_PARITY : ST_STOP;
                    end else begin
                        bitCnt <= bitCnt + 1'b1;
                    end
                end
                ST_PARITY: begin
                    parityBit <= rxLine;
                    bitTimer <= bitTime(divisor) - 1'b1;
                    rxState <= ST_STOP;
                end
                ST_STOP: begin
                    rxState <= ST_IDLE;
                end
                default: begin
                    rxState <= ST_IDLE;
                end
            endcase
        end
    end

    // Overrun flag: hardware sets it, software only clears it. A set cannot meet a
    // clear in one cycle because no character is taken while the flag is up.
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            overrun <= 1'b0;
        end else if (overrunEvent) begin
            overrun <= 1'b1;
        end else if (overrunClear) begin
            overrun <= 1'b0;
        end
    end

    // Software configuration registers.
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            addrDetect <= 1'b0;
            format <= `URS_CTL_RESET;
            divisor <= `URS_DIV_RESET;
            irqEnable <= `URS_EV_RESET;
        end else begin
            if (wrLane0 && wrAddr == `URS_OFF_STATUS) begin
                addrDetect <= s_axi_wdata[`URS_ST_ADDR_DETECT];
            end
            if (wrLane0 && wrAddr == `URS_OFF_CONTROL) begin
                format <= s_axi_wdata[`URS_CTL_W-1:0];
            end
            if (wrLane0 && wrAddr == `URS_OFF_DIVISOR) begin
                divisor[7:0] <= s_axi_wdata[7:0];
            end
            if (wrLane1 && wrAddr == `URS_OFF_DIVISOR) begin
                divisor[15:8] <= s_axi_wdata[15:8];
            end
            if (wrLane0 && wrAddr == `URS_OFF_IRQ_ENABLE) begin
                irqEnable <= s_axi_wdata[`URS_EV_W-1:0];
            end
        end
    end

    // Sticky interrupt events; a new event in the clearing cycle survives the clear.
    assign events = {pushChar && (parityBad || framingBad), overrunEvent, pushChar};
    assign clearMask = (wrLane0 && wrAddr == `URS_OFF_IRQ_CLEAR)
        ? s_axi_wdata[`URS_EV_W-1:0] : `URS_EV_RESET;

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irqStatus <= `URS_EV_RESET;
            irq <= 1'b0;
        end else begin
            irqStatus <= (irqStatus & ~clearMask) | events;
            irq <= |(irqStatus & irqEnable);
        end
    end

    // Read data multiplexer; status flags are computed live from the block's state.
    always @* begin
        next_rdata = {`URS_DATA_W{1'b0}};
        next_rresp = `URS_RESP_OKAY;
        case (rdAddr)
            `URS_OFF_STATUS: begin
                next_rdata[`URS_ST_ADDR_DETECT] = addrDetect;
                next_rdata[`URS_ST_IDLE] = (rxState == ST_IDLE);
                next_rdata[`URS_ST_PARITY_ERR] = !fifoEmpty && fifoHead[`URS_ENT_PARITY_ERROR_FLAG];
                next_rdata[`URS_ST_FRAMING_ERR] = !fifoEmpty && fifoHead[`URS_ENT_FRAMING_ERROR_FLAG];
                next_rdata[`URS_ST_OVERRUN] = overrun;
                next_rdata[`URS_ST_DATA_AVAIL] = !fifoEmpty;
            end
            `URS_OFF_CONTROL: begin
                next_rdata[`URS_CTL_W-1:0] = format;
            end
            `URS_OFF_DIVISOR: begin
                next_rdata[`URS_DIV_W-1:0] = divisor;
            end
            `URS_OFF_DATA: begin
                if (!fifoEmpty) begin
                    next_rdata[`URS_CHAR_W-1:0] = fifoHead[`URS_CHAR_W-1:0];
                end
            end
            `URS_OFF_IRQ_STATUS: begin
                next_rdata[`URS_EV_W-1:0] = irqStatus;
            end
            `URS_OFF_IRQ_ENABLE: begin
                next_rdata[`URS_EV_W-1:0] = irqEnable;
            end
            `URS_OFF_IRQ_CLEAR: begin
                next_rdata = {`URS_DATA_W{1'b0}};
            end
            default: begin
                next_rresp = `URS_RESP_SLVERR;
            end
        endcase
    end

    // Write channel: ready is raised for one cycle once address and data both wait
    // and no response is pending, which keeps one write in flight at a time.
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `URS_RESP_OKAY;
        end else begin
            if (wrEn) begin
                s_axi_awready <= 1'b0;
                s_axi_wready <= 1'b0;
                s_axi_bvalid <= 1'b1;
                case (wrAddr)
                    `URS_OFF_STATUS, `URS_OFF_CONTROL, `URS_OFF_DIVISOR,
                    `URS_OFF_IRQ_ENABLE, `URS_OFF_IRQ_CLEAR: begin
                        s_axi_bresp <= `URS_RESP_OKAY;
                    end
                    default: begin
                        s_axi_bresp <= `URS_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read channel: data is captured at the address handshake, the same edge that pops.
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= {`URS_DATA_W{1'b0}};
            s_axi_rresp <= `URS_RESP_OKAY;
        end else begin
            if (rdEn) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= next_rdata;
                s_axi_rresp <= next_rresp;
            end else if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
                s_axi_arready <= 1'b1;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

// File: sim/urs_receive_status_monitor.sv
// Checker of the bus answers of the receive status block.
`timescale 1ns/100ps
`include "urs_consts.vh"
module urs_receive_status_monitor (
    input wire clock,
    input wire rst_n,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [`URS_ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [`URS_DATA_W-1:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready
);
    // The read address is kept so the answer a cycle later can be judged.
    reg [`URS_ADDR_W-1:0] rdAddr;
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdAddr <= 5'h00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rdAddr <= s_axi_araddr;
        end
    end
    default clocking mcb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    wr_ready_pair_a: assert property (s_axi_awready == s_axi_wready)
        else $error("write readies differ");
    wr_ready_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("write ready longer than one cycle");
    wr_answer_a: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
        else $error("write response late");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    rd_ready_cause_a: assert property (s_axi_arready |-> $past(s_axi_arvalid))
        else $error("read ready without request");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    status_upper_a: assert property (s_axi_rvalid && rdAddr[4:2] == 3'h0
        |-> s_axi_rdata[31:6] == 26'h0)
        else $error("status upper bits set");
    empty_errors_a: assert property (s_axi_rvalid && rdAddr[4:2] == 3'h0
        && !s_axi_rdata[0] |-> s_axi_rdata[3:2] == 2'h0)
        else $error("error flag with empty buffer");
    unmapped_resp_a: assert property (s_axi_rvalid && rdAddr[4:2] == 3'h7
        |-> s_axi_rresp == `URS_RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read answered");
    // Every mapped register, the write-only clear included, answers a read with OKAY.
    mapped_resp_a: assert property (s_axi_rvalid && rdAddr[4:2] != 3'h7
        |-> s_axi_rresp == `URS_RESP_OKAY)
        else $error("mapped read refused");
endmodule

// File: sim/urs_serial_tx.sv
// Remote serial transmitter that drives the receive line.
`timescale 1ns/100ps
module urs_serial_tx #(
    parameter BIT_LEN = 16
) (
    input wire clock,
    output reg rxLine
);
    initial rxLine = 1'b1;
    // One character LSB first; par 0 none, 1 even, 2 wrong. A bad stop is cut short so
    // that any start the receiver takes from its tail fails the start-bit check.
    task send(input [8:0] ch, input nine, input [1:0] par, input badStop);
        integer i;
        begin
            @(posedge clock);
            rxLine <= 1'b0;
            repeat (BIT_LEN) @(posedge clock);
            for (i = 0; i < (nine ? 9 : 8); i = i + 1) begin
                rxLine <= ch[i];
                repeat (BIT_LEN) @(posedge clock);
            end
            if (par != 2'h0) begin
                rxLine <= (^ch[7:0]) ^ (par == 2'h2);
                repeat (BIT_LEN) @(posedge clock);
            end
            rxLine <= !badStop;
            repeat (BIT_LEN * 3 / 4) @(posedge clock);
            rxLine <= 1'b1;
            repeat (BIT_LEN * 2) @(posedge clock);
        end
    endtask
endmodule

// File: sim/urs_receive_status_tb.sv
// Register-level testbench of the receive status block.
`timescale 1ns/100ps
`include "urs_consts.vh"
module urs_receive_status_tb;
    reg clock = 1'b0;
    reg rst_n = 1'b0;
    reg [4:0] awaddr = 5'h00;
    reg [4:0] araddr = 5'h00;
    reg [31:0] wdata = 32'h0;
    reg awvalid = 1'b0;
    reg wvalid = 1'b0;
    reg bready = 1'b0;
    reg arvalid = 1'b0;
    reg rready = 1'b0;
    wire awready, wready, bvalid, arready, rvalid, irq, rxLine;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    reg [31:0] rd;
    reg [1:0] rr;
    reg [1:0] br;
    integer err_total = 0;
    integer comparisons = 0;
    urs_receive_status dut (.clock(clock), .rst_n(rst_n), .rxLine(rxLine),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .irq(irq));
    urs_serial_tx #(.BIT_LEN(16)) tx (.clock(clock), .rxLine(rxLine));
    // Clock of 8 ns.
    initial forever #4 clock = !clock;
    task close_out;
        begin
            $display("mismatches %0d comparisons %0d", err_total, comparisons);
            if (err_total == 0 && comparisons > 0) begin
                $display("verification passed");
            end else begin
                $display("verification failed");
            end
            $finish;
        end
    endtask
    task checkWord(input [31:0] got, input [31:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    // The pin lags its status by a cycle, so two edges pass before it is judged.
    task checkIrq(input exp);
        begin
            repeat (2) @(posedge clock);
            checkWord({31'h0, irq}, {31'h0, exp});
        end
    endtask
    // Each channel is released at the edge where its handshake is seen; flags track them.
    task axiWrite(input [4:0] a, input [31:0] d);
        reg [2:0] p;
        integer n;
        begin
            @(posedge clock);
            awaddr <= a;
            wdata <= d;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            p = 3'h7;
            n = 0;
            while (p != 3'h0 && n < 200) begin
                @(posedge clock);
                n = n + 1;
                if (p[0] && awready) begin
                    awvalid <= 1'b0;
                    p[0] = 1'b0;
                end
                if (p[1] && wready) begin
                    wvalid <= 1'b0;
                    p[1] = 1'b0;
                end
                if (p[2] && bvalid) begin
                    bready <= 1'b0;
                    br = bresp;
                    p[2] = 1'b0;
                end
            end
            if (n >= 200) begin
                err_total = err_total + 1;
                close_out;
            end
        end
    endtask
    task axiRead(input [4:0] a);
        reg [1:0] p;
        integer n;
        begin
            @(posedge clock);
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
            p = 2'h3;
            n = 0;
            while (p != 2'h0 && n < 200) begin
                @(posedge clock);
                n = n + 1;
                if (p[0] && arready) begin
                    arvalid <= 1'b0;
                    p[0] = 1'b0;
                end
                if (p[1] && rvalid) begin
                    rready <= 1'b0;
                    rd = rdata;
                    rr = rresp;
                    p[1] = 1'b0;
                end
            end
            if (n >= 200) begin
                err_total = err_total + 1;
                close_out;
            end
        end
    endtask
    task expRead(input [4:0] a, input [31:0] e);
        begin
            axiRead(a);
            checkWord(rd, e);
        end
    endtask
    // Watchdog well beyond the expected run of about 4000 cycles.
    initial begin
        #(8 * 40000);
        err_total = err_total + 1;
        close_out;
    end
    // Main sequence; status reads 0x10 when idle and empty.
    initial begin
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        expRead(5'h00, 32'h10);
        expRead(5'h08, 32'h043d);
        expRead(5'h04, 32'h0);
        // Ones written to every read-only flag and to overrun must not stick.
        axiWrite(5'h00, 32'h1f);
        expRead(5'h00, 32'h10);
        axiWrite(5'h08, 32'h10);
        checkWord({30'h0, br}, {30'h0, `URS_RESP_OKAY});
        axiWrite(5'h14, 32'h7);
        tx.send(9'h5a, 1'b0, 2'h0, 1'b0);
        checkIrq(1'b1);
        expRead(5'h00, 32'h11);
        expRead(5'h0c, 32'h5a);
        expRead(5'h00, 32'h10);
        expRead(5'h10, 32'h1);
        axiWrite(5'h14, 32'h0);
        checkIrq(1'b0);
        axiWrite(5'h14, 32'h7);
        checkIrq(1'b1);
        axiWrite(5'h18, 32'h7);
        checkIrq(1'b0);
        expRead(5'h10, 32'h0);
        fork
            tx.send(9'h33, 1'b0, 2'h0, 1'b0);
            begin
                repeat (60) @(posedge clock);
                expRead(5'h00, 32'h0);
            end
        join
        expRead(5'h0c, 32'h33);
        // A flagged character ahead of a clean one: flags follow the head.
        axiWrite(5'h04, 32'h2);
        tx.send(9'hc3, 1'b0, 2'h2, 1'b0);
        tx.send(9'hc3, 1'b0, 2'h1, 1'b0);
        expRead(5'h00, 32'h19);
        expRead(5'h10, 32'h5);
        expRead(5'h0c, 32'hc3);
        expRead(5'h00, 32'h11);
        expRead(5'h0c, 32'hc3);
        // Odd parity: the partner's inverted even parity is correct, plain even is not.
        axiWrite(5'h04, 32'h6);
        tx.send(9'h3c, 1'b0, 2'h2, 1'b0);
        tx.send(9'h3c, 1'b0, 2'h1, 1'b0);
        expRead(5'h00, 32'h11);
        expRead(5'h0c, 32'h3c);
        expRead(5'h00, 32'h19);
        expRead(5'h0c, 32'h3c);
        axiWrite(5'h04, 32'h0);
        tx.send(9'h81, 1'b0, 2'h0, 1'b1);
        tx.send(9'h7e, 1'b0, 2'h0, 1'b0);
        expRead(5'h00, 32'h15);
        expRead(5'h0c, 32'h81);
        expRead(5'h00, 32'h11);
        expRead(5'h0c, 32'h7e);
        axiWrite(5'h18, 32'h7);
        // Five characters into a four-deep buffer.
        repeat (5) tx.send(9'h10, 1'b0, 2'h0, 1'b0);
        expRead(5'h00, 32'h13);
        expRead(5'h10, 32'h3);
        expRead(5'h0c, 32'h10);
        tx.send(9'h55, 1'b0, 2'h0, 1'b0);
        axiWrite(5'h00, 32'h02);
        expRead(5'h00, 32'h13);
        axiWrite(5'h00, 32'h00);
        expRead(5'h00, 32'h10);
        expRead(5'h0c, 32'h0);
        tx.send(9'h66, 1'b0, 2'h0, 1'b0);
        expRead(5'h0c, 32'h66);
        // Address detect in nine-bit mode, then without it.
        axiWrite(5'h04, 32'h1);
        axiWrite(5'h00, 32'h20);
        tx.send(9'h0a5, 1'b1, 2'h0, 1'b0);
        tx.send(9'h1a5, 1'b1, 2'h0, 1'b0);
        expRead(5'h00, 32'h31);
        expRead(5'h0c, 32'h1a5);
        expRead(5'h00, 32'h30);
        axiWrite(5'h04, 32'h0);
        tx.send(9'h0a5, 1'b0, 2'h0, 1'b0);
        expRead(5'h0c, 32'ha5);
        expRead(5'h1c, 32'h0);
        checkWord({30'h0, rr}, {30'h0, `URS_RESP_SLVERR});
        axiWrite(5'h1c, 32'h1);
        checkWord({30'h0, br}, {30'h0, `URS_RESP_SLVERR});
        close_out;
    end
endmodule
bind urs_receive_status urs_receive_status_monitor mon (.clock(clock), .rst_n(rst_n),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));
